// file: core/ccpg_pkg.sv
// package for the capture/compare power gate bank
package ccpg_pkg;
  localparam logic [11:0] CCPG_ADDR_DISABLE_CTRL = 12'h000;
  localparam logic [15:0] CCPG_DISABLE_CTRL_RESET = 16'h0000;
  localparam logic [15:0] CCPG_DISABLE_CTRL_WMASK = 16'hC303;
  localparam int CCPG_BIT_CAPTURE_EIGHT_OFF = 15;
  localparam int CCPG_BIT_CAPTURE_SEVEN_OFF = 14;
  localparam int CCPG_BIT_CAPTURE_TWO_OFF = 9;
  localparam int CCPG_BIT_CAPTURE_ONE_OFF = 8;
  localparam int CCPG_BIT_COMPARE_TWO_OFF = 1;
  localparam int CCPG_BIT_COMPARE_ONE_OFF = 0;
  localparam int CCPG_PIN_COUNT = 8;

  typedef struct packed {
    logic capture_eight_off;
    logic capture_seven_off;
    logic capture_two_off;
    logic capture_one_off;
    logic compare_two_off;
    logic compare_one_off;
  } ccpg_gate_type;
endpackage : ccpg_pkg

// file: core/ccpg_pin_share.sv
// pin sharing between a peripheral and a parallel port bit
module ccpg_pin_share
  import ccpg_pkg::*;
#(
  parameter int WIDTH = CCPG_PIN_COUNT
)
(
  input wire logic [WIDTH-1:0] periph_out,
  input wire logic [WIDTH-1:0] periph_drive,
  input wire logic [WIDTH-1:0] port_out,
  input wire logic [WIDTH-1:0] port_drive,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out,
  output logic [WIDTH-1:0] pin_oe_n,
  output logic [WIDTH-1:0] periph_in
);
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_pin
      // an active peripheral owns the driver; the port bit only fills in
      assign pin_out[g] = periph_drive[g] ? periph_out[g] : port_out[g];
      assign pin_oe_n[g] = ~(periph_drive[g] | port_drive[g]);
      // block loop-through: while the port alone drives the pin, the peripheral input reads 0
      assign periph_in[g] = (port_drive[g] & ~periph_drive[g]) ? 1'b0 : pin_in[g];
    end
  endgenerate
endmodule : ccpg_pin_share

// file: core/ccpg_bank.sv
// capture/compare power gate register bank with APB slave
// Function
// - bit 15 set disables capture unit eight
// - bit 14 set disables capture unit seven
// - bit 9 set disables capture unit two
// - bit 8 set disables capture unit one
// - bit 1 set disables compare unit two
// - general pins shared between peripherals and port
//
// The APB register port and the register addresses were chosen for this implementation.
module ccpg_bank
  import ccpg_pkg::*;
#(
  parameter int PIN_WIDTH = CCPG_PIN_COUNT
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output ccpg_pkg::ccpg_gate_type gate,
  input wire logic [PIN_WIDTH-1:0] periph_out,
  input wire logic [PIN_WIDTH-1:0] periph_drive,
  input wire logic [PIN_WIDTH-1:0] port_out,
  input wire logic [PIN_WIDTH-1:0] port_drive,
  input wire logic [PIN_WIDTH-1:0] pin_in,
  output logic [PIN_WIDTH-1:0] pin_out,
  output logic [PIN_WIDTH-1:0] pin_oe_n,
  output logic [PIN_WIDTH-1:0] periph_in
);
  import ccpg_pkg::*;

  logic [15:0] disable_ctrl;
  logic [PIN_WIDTH-1:0] pin_meta;
  logic [PIN_WIDTH-1:0] pin_sync;
  logic access;
  logic hit;

  function automatic logic addr_hit(input logic [11:0] a);
    addr_hit = (a == CCPG_ADDR_DISABLE_CTRL);
  endfunction : addr_hit

  assign access = psel & penable;
  assign hit = addr_hit(paddr);
  // zero wait states keeps the slave trivially predictable
  assign pready = 1'b1;
  assign pslverr = access & ~hit;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      disable_ctrl <= CCPG_DISABLE_CTRL_RESET;
    else if (access && pwrite && hit)
    begin
      // unimplemented bits stay zero through the write mask
      if (pstrb[0])
        disable_ctrl[7:0] <= pwdata[7:0] & CCPG_DISABLE_CTRL_WMASK[7:0];
      if (pstrb[1])
        disable_ctrl[15:8] <= pwdata[15:8] & CCPG_DISABLE_CTRL_WMASK[15:8];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
      prdata <= addr_hit(paddr) ? {16'h0000, disable_ctrl} : 32'h00000000;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gate <= '0;
    end
    else
    begin
      gate.capture_eight_off <= disable_ctrl[CCPG_BIT_CAPTURE_EIGHT_OFF];
      gate.capture_seven_off <= disable_ctrl[CCPG_BIT_CAPTURE_SEVEN_OFF];
      gate.capture_two_off <= disable_ctrl[CCPG_BIT_CAPTURE_TWO_OFF];
      gate.capture_one_off <= disable_ctrl[CCPG_BIT_CAPTURE_ONE_OFF];
      gate.compare_two_off <= disable_ctrl[CCPG_BIT_COMPARE_TWO_OFF];
      gate.compare_one_off <= disable_ctrl[CCPG_BIT_COMPARE_ONE_OFF];
    end
  end

  // pins are asynchronous to pclk
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta <= '0;
      pin_sync <= '0;
    end
    else
    begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  ccpg_pin_share #(
    .WIDTH(PIN_WIDTH)
  ) u_pin_share (
    .periph_out(periph_out),
    .periph_drive(periph_drive),
    .port_out(port_out),
    .port_drive(port_drive),
    .pin_in(pin_sync),
    .pin_out(pin_out),
    .pin_oe_n(pin_oe_n),
    .periph_in(periph_in)
  );
endmodule : ccpg_bank

// file: sim/ccpg_bank_sva.sv
// assertions on the power gate bank register port
module ccpg_bank_sva
  import ccpg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire ccpg_pkg::ccpg_gate_type gate
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // gate lags the write edge by one register stage
  wire w = psel && penable && pwrite && paddr == CCPG_ADDR_DISABLE_CTRL;
  wire h = w && pstrb[1];
  wire l = w && pstrb[0];
  a_gate_c8: assert property (h |-> ##2 gate.capture_eight_off == $past(pwdata[15], 2))
    else $error("c8 gate");
  a_gate_c7: assert property (h |-> ##2 gate.capture_seven_off == $past(pwdata[14], 2))
    else $error("c7 gate");
  a_gate_c2: assert property (h |-> ##2 gate.capture_two_off == $past(pwdata[9], 2))
    else $error("c2 gate");
  a_gate_c1: assert property (h |-> ##2 gate.capture_one_off == $past(pwdata[8], 2))
    else $error("c1 gate");
  a_gate_o2: assert property (l |-> ##2 gate.compare_two_off == $past(pwdata[1], 2))
    else $error("o2 gate");
  a_gate_o1: assert property (l |-> ##2 gate.compare_one_off == $past(pwdata[0], 2))
    else $error("o1 gate");
  a_read_zeros: assert property (psel && !penable && !pwrite |=> !(prdata & 32'hFFFF3CFC))
    else $error("bits not zero");
endmodule : ccpg_bank_sva

// file: sim/tb_top.sv
// bench for the power gate bank
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import ccpg_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = 0, a;
  logic [31:0] pwdata = 0, prdata, rd, r, d, s = 32'h01B7CD8D;
  logic [3:0] pstrb = 0;
  logic [7:0] periph_out = 0, periph_drive = 0, port_out = 0, port_drive = 0, pin_out, pin_oe_n;
  logic [7:0] pin_in = 8'h00, periph_in;
  ccpg_gate_type gate;
  int failures = 0, checks_done = 0, m = 0, i;
  always #20 pclk = ~pclk;
  ccpg_bank DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .gate, .periph_out, .periph_drive, .port_out, .port_drive,
    .pin_in, .pin_out, .pin_oe_n, .periph_in);
  function automatic logic [31:0] xs();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task wrap_up();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up
  task chk(input logic ok, input string t);
    checks_done++;
    if (ok !== 1'b1)
    begin
      failures++;
      $display("mismatch %0t %s", $time, t);
    end
  endtask : chk
  task apb(input logic wr, input logic [31:0] dat, input logic [3:0] b);
    {psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, wr, a, dat, b};
    @(posedge pclk);
    penable <= 1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end
    while (pready !== 1'b1 && i < 9);
    chk(pready === 1'b1 && pslverr === (a != 0), "answer");
    if (pready !== 1'b1)
      wrap_up();
    rd = prdata;
    {psel, penable} <= 2'b00;
    // an idle edge after each transfer keeps the next call from re-driving psel in one step
    @(posedge pclk);
  endtask : apb
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    a = 12'h000;
    apb(0, 0, 0);
    chk(rd === 32'h00000000, "reset read");
    chk(gate === '0, "reset gate");
    repeat (60)
    begin
      r = xs();
      d = xs();
      a = {9'h0, r[0], 2'b00};
      apb(1, d, r[7:4]);
      if (a == 0 && r[4]) m[7:0] = d[7:0];
      if (a == 0 && r[5]) m[15:8] = d[15:8];
      m &= 'hC303;
      apb(0, 0, 0);
      chk(rd === 32'(a == 0 ? m : 0), "read");
      chk(gate === {m[15], m[14], m[9], m[8], m[1], m[0]}, "gate");
      {periph_out, periph_drive, port_out, port_drive} <= r;
      pin_in <= d[31:24];
      // the pin level needs two synchroniser edges before it reaches the peripheral input
      repeat (3) @(posedge pclk);
      chk(periph_in === (d[31:24] & ~(port_drive & ~periph_drive)), "loop");
      chk(pin_out === ((periph_drive & periph_out) | (~periph_drive & port_out)), "pin");
      chk(pin_oe_n === ~(periph_drive | port_drive), "oe");
    end
    wrap_up();
  end
endmodule : tb_top

bind ccpg_bank ccpg_bank_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pstrb, .prdata, .gate);
